// [design/rx_buffer2.sv]
// two-entry receive buffer with valid and ready on both sides
`default_nettype none
module rx_buffer2 #(
   parameter int WIDTH = 9
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] head_q;
   logic [WIDTH-1:0] tail_q;
   logic [1:0] count_q;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data = head_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= 2'h0;
      end else if (push && !pop) begin
         count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
         count_q <= count_q - 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         head_q <= '0;
         tail_q <= '0;
      end else begin
         if (pop) begin
            head_q <= (count_q == 2'h2) ? tail_q : in_data;
         end else if (push && count_q == 2'h0) begin
            head_q <= in_data;
         end
         if (push && ((count_q == 2'h1 && !pop) || count_q == 2'h2)) begin
            tail_q <= in_data;
         end
      end
   end
endmodule : rx_buffer2
`default_nettype wire

// [design/uart_irda.sv]
// serial transmitter and receiver with multiprocessor mode and infrared codec
// Summary of operation
// [RQ1] transmit request rises at once while enabled and the holding register is empty
// [RQ2] a written byte moves to the shifter by itself and is sent
// [RQ3] software clears the transmit request in the interrupt controller before returning
// [RQ4] in nine-bit mode the multiprocessor transmit bit is sent as ninth bit
// [RQ5] software sets divider, pins, multiprocessor options, then receiver and parity
// [RQ6] parity may be enabled only with nine-bit mode off, even or odd
// [RQ7] byte-available flag is 1 while a received byte waits, else 0
// [RQ8] driver enable is active high with polarity 0, active low with 1
// [RQ9] receiver off and readback 1: zero count raises receive request, reads live count
// [RQ10] receiver on: readback bit selects reload or live count, no request
// [RQ11] live count reads latch nothing; low and high bytes may differ
// [RQ12] mask 0: data and errors request; mask 1: only errors request
// [RQ13] codec enable routes all traffic through infrared encoder and decoder
// [RQ14] upper mode bit set: address bytes must match node address to deliver
// [RQ15] decoder seeks next pulse from four before to eight after expected time
// [RQ16] no pulse in the window: bit is 1, decoder returns idle
// [RQ17] every falling edge clears the decoder clock counter
// [RQ18] decoder resync leaves receiver timing alone; receiver aligns on start bits
// [RQ19] software sets codec enable before enabling the pin alternate function
// [RQ20] receiver-on bit disables receiver at 0, enables it at 1
// [RQ21] transmit-empty flag is 1 when holding register empty, 0 when full
// [RQ22] baud counter reloads from the divider at zero, giving the bit tick; here each bit spans 16 such ticks
// [RQ23] receive errors set their flag and request regardless of the data mask
`default_nettype none
`include "uart_irda_consts.svh"
module uart_irda (
   input wire logic mclk,
   input wire logic reset_n,
   input wire uart_irda_pkg::uart_cfg_t cfg,
   input wire logic tx_write,
   input wire logic [7:0] tx_byte,
   output logic tx_data_empty_q,
   output logic tx_irq_q,
   output logic rx_byte_available_q,
   output uart_irda_pkg::rx_word_t rx_word_q,
   input wire logic rx_read,
   output logic rx_irq_q,
   output logic parity_err_q,
   output logic framing_err_q,
   output logic overrun_err_q,
   input wire logic err_clear,
   output logic [15:0] baud_read_q,
   output logic uart_txd_q,
   input wire logic uart_rxd,
   output logic ir_txd_q,
   input wire logic ir_rxd,
   output logic line_driver_enable_q
);
   import uart_irda_pkg::*;

   logic [15:0] baud_cnt_q;
   logic tick;
   logic mp_on;
   logic ninth_on;

   assign mp_on = (cfg.multiproc_mode_select != `MP_OFF);
   assign ninth_on = mp_on || cfg.parity_enable;

   // baud generator: tick each time the down-counter reaches zero
   assign tick = (baud_cnt_q == `BAUD_RESET);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         baud_cnt_q <= `BAUD_RESET;
      end else if (tick) begin
         baud_cnt_q <= cfg.baud_divider; // [RQ22]
      end else begin
         baud_cnt_q <= baud_cnt_q - 16'h0001;
      end
   end

   // no latch of the upper byte: each read sees the count of the cycle before it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         baud_read_q <= `BAUD_RESET;
      end else begin
         baud_read_q <= cfg.baud_readback_ctl ? baud_cnt_q : cfg.baud_divider; // [RQ10] [RQ11]
      end
   end

   // ---------------- transmitter ----------------
   ser_state_t tx_state_q;
   logic [7:0] tx_hold_q;
   logic [7:0] tx_shift_q;
   logic tx_ninth_q;
   logic [3:0] tx_sub_q;
   logic [2:0] tx_bit_q;
   logic tx_stop2_q;
   logic tx_line;
   logic tx_load;

   assign tx_load = (tx_state_q == SER_IDLE) && !tx_data_empty_q && cfg.tx_enable;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_data_empty_q <= 1'b1;
         tx_hold_q <= 8'h00;
      end else if (tx_write && tx_data_empty_q) begin
         tx_hold_q <= tx_byte;
         tx_data_empty_q <= 1'b0; // [RQ21]
      end else if (tx_load) begin
         tx_data_empty_q <= 1'b1; // [RQ2] [RQ21]
      end
   end

   // level request, follows the empty flag with no other event needed
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_irq_q <= 1'b0;
      end else begin
         tx_irq_q <= cfg.tx_enable && tx_data_empty_q; // [RQ1]
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_q <= SER_IDLE;
         tx_shift_q <= 8'h00;
         tx_ninth_q <= 1'b0;
         tx_sub_q <= 4'h0;
         tx_bit_q <= 3'h0;
         tx_stop2_q <= 1'b0;
      end else if (tx_load) begin
         tx_state_q <= SER_START; // [RQ2]
         tx_shift_q <= tx_hold_q;
         tx_ninth_q <= mp_on ? cfg.multiproc_bit_tx // [RQ4]
                             : (^tx_hold_q) ^ cfg.parity_odd;
         tx_sub_q <= 4'h0;
         tx_bit_q <= 3'h0;
         tx_stop2_q <= cfg.two_stop;
      end else if (tick && tx_state_q != SER_IDLE) begin
         tx_sub_q <= tx_sub_q + 4'h1;
         if (tx_sub_q == `OVS_LAST) begin
            case (tx_state_q)
               SER_START: begin
                  tx_state_q <= SER_DATA;
               end
               SER_DATA: begin
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == `DATA_LAST) begin
                     tx_state_q <= ninth_on ? SER_NINTH : SER_STOP;
                  end
               end
               SER_NINTH: begin
                  tx_state_q <= SER_STOP;
               end
               SER_STOP: begin
                  if (tx_stop2_q) begin
                     tx_stop2_q <= 1'b0;
                  end else begin
                     tx_state_q <= SER_IDLE;
                  end
               end
               default: begin
                  tx_state_q <= SER_IDLE;
               end
            endcase
         end
      end
   end

   always_comb begin
      case (tx_state_q)
         SER_START: tx_line = 1'b0;
         SER_DATA: tx_line = tx_shift_q[0];
         SER_NINTH: tx_line = tx_ninth_q;
         default: tx_line = 1'b1;
      endcase
   end

   // encoder sends a short high pulse for every zero bit; plain pin idles high meanwhile
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         uart_txd_q <= 1'b1;
         ir_txd_q <= 1'b0;
      end else begin
         uart_txd_q <= cfg.infrared_codec_enable ? 1'b1 : tx_line; // [RQ13]
         ir_txd_q <= cfg.infrared_codec_enable && !tx_line
                     && (tx_sub_q < `IR_PULSE_TICKS); // [RQ13]
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         line_driver_enable_q <= 1'b0;
      end else begin
         line_driver_enable_q <= (tx_state_q != SER_IDLE) ^ cfg.driver_enable_polarity; // [RQ8]
      end
   end

   // ---------------- infrared decoder ----------------
   dec_state_t dec_state_q;
   logic [4:0] dec_cnt_q;
   logic ir_prev_q;
   logic ir_fall;
   logic dec_out;

   assign ir_fall = ir_prev_q && !ir_rxd;
   // a pulse drives the decoded line low for one bit time from its edge
   assign dec_out = !((dec_state_q == DEC_TRACK) && (dec_cnt_q < `OVS_TICKS));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ir_prev_q <= 1'b1;
         dec_state_q <= DEC_IDLE;
         dec_cnt_q <= 5'h00;
      end else begin
         ir_prev_q <= ir_rxd;
         if (!cfg.infrared_codec_enable) begin
            dec_state_q <= DEC_IDLE;
            dec_cnt_q <= 5'h00;
         end else if (ir_fall && (dec_state_q == DEC_IDLE || dec_cnt_q >= `IR_CNT_OPEN)) begin
            dec_state_q <= DEC_TRACK; // [RQ15]
            dec_cnt_q <= 5'h00; // [RQ17]
         end else if (ir_fall) begin
            dec_cnt_q <= 5'h00; // [RQ17]
         end else if (tick && dec_state_q == DEC_TRACK) begin
            if (dec_cnt_q == `IR_CNT_MAX) begin
               dec_state_q <= DEC_IDLE; // [RQ16]
               dec_cnt_q <= 5'h00;
            end else begin
               dec_cnt_q <= dec_cnt_q + 5'h01;
            end
         end
      end
   end

   // ---------------- receiver ----------------
   ser_state_t rx_state_q;
   logic rx_in;
   logic [3:0] rx_sub_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_shift_q;
   logic rx_ninth_q;
   logic addr_ok_q;
   logic buf_in_ready;
   logic push_valid;
   logic done;
   logic stop_bad;
   logic par_bad;
   logic is_addr;
   logic deliver;
   logic buf_valid;
   rx_word_t buf_word;

   // the receiver realigns only on its own start detection, never on decoder resyncs
   assign rx_in = cfg.infrared_codec_enable ? dec_out : uart_rxd; // [RQ13] [RQ18]
   // stop judged in mid bit; at its leading edge the last data level could still show
   assign done = tick && (rx_state_q == SER_STOP) && (rx_sub_q == `OVS_LAST);
   assign stop_bad = !rx_in;
   assign par_bad = cfg.parity_enable && !mp_on
                    && (((^rx_shift_q) ^ cfg.parity_odd) != rx_ninth_q);
   assign is_addr = mp_on && rx_ninth_q;
   assign deliver = !cfg.multiproc_mode_select[`MP_MATCH_BIT]
                    || (is_addr ? (rx_shift_q == cfg.node_address) : addr_ok_q); // [RQ14]
   assign push_valid = done && !stop_bad && deliver;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_q <= SER_IDLE;
         rx_sub_q <= 4'h0;
         rx_bit_q <= 3'h0;
         rx_shift_q <= 8'h00;
         rx_ninth_q <= 1'b0;
      end else if (!cfg.rx_enable) begin
         rx_state_q <= SER_IDLE; // [RQ20]
      end else if (tick) begin
         rx_sub_q <= rx_sub_q + 4'h1;
         case (rx_state_q)
            SER_IDLE: begin
               if (!rx_in) begin
                  rx_state_q <= SER_START; // [RQ18]
                  rx_sub_q <= 4'h0;
                  rx_ninth_q <= 1'b0;
               end
            end
            SER_START: begin
               if (rx_sub_q == `OVS_MID) begin
                  // a glitch shorter than half a bit is not a start bit
                  rx_state_q <= rx_in ? SER_IDLE : SER_DATA;
                  rx_sub_q <= 4'h0;
                  rx_bit_q <= 3'h0;
               end
            end
            SER_DATA: begin
               if (rx_sub_q == `OVS_LAST) begin
                  rx_shift_q <= {rx_in, rx_shift_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == `DATA_LAST) begin
                     rx_state_q <= ninth_on ? SER_NINTH : SER_STOP;
                  end
               end
            end
            SER_NINTH: begin
               if (rx_sub_q == `OVS_LAST) begin
                  rx_ninth_q <= rx_in;
                  rx_state_q <= SER_STOP;
               end
            end
            SER_STOP: begin
               if (rx_sub_q == `OVS_LAST) begin
                  rx_state_q <= SER_IDLE;
               end
            end
            default: begin
               rx_state_q <= SER_IDLE;
            end
         endcase
      end
   end

   // remembers whether the last address byte named this node
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         addr_ok_q <= 1'b0;
      end else if (done && is_addr) begin
         addr_ok_q <= (rx_shift_q == cfg.node_address); // [RQ14]
      end
   end

   rx_buffer2 #(
      .WIDTH($bits(rx_word_t))
   ) u_rx_buffer (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(push_valid),
      .in_ready(buf_in_ready),
      .in_data({rx_ninth_q, rx_shift_q}),
      .out_valid(buf_valid),
      .out_ready(rx_read),
      .out_data(buf_word)
   );

   // buffer output registered again so the flag and word come from flops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_byte_available_q <= 1'b0;
         rx_word_q <= '0;
      end else begin
         rx_byte_available_q <= buf_valid && !rx_read; // [RQ7]
         rx_word_q <= buf_word;
      end
   end

   // error flags: a new error in the clear cycle wins over the clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         parity_err_q <= 1'b0;
         framing_err_q <= 1'b0;
         overrun_err_q <= 1'b0;
      end else begin
         parity_err_q <= (done && par_bad) || (parity_err_q && !err_clear); // [RQ23]
         framing_err_q <= (done && stop_bad) || (framing_err_q && !err_clear); // [RQ23]
         overrun_err_q <= (push_valid && !buf_in_ready)
                          || (overrun_err_q && !err_clear); // [RQ23]
      end
   end

   // one-cycle receive request for data, errors or the timer use of the baud counter
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_irq_q <= 1'b0;
      end else begin
         rx_irq_q <= (push_valid && buf_in_ready && !cfg.rx_data_irq_mask) // [RQ12]
                     || (done && (par_bad || stop_bad)) // [RQ23]
                     || (push_valid && !buf_in_ready) // [RQ23]
                     || (!cfg.rx_enable && cfg.baud_readback_ctl && tick); // [RQ9]
      end
   end
endmodule : uart_irda
`default_nettype wire

// [design/uart_irda_consts.svh]
// timing and field constants of the serial block with infrared codec
`ifndef UART_IRDA_CONSTS_SVH
`define UART_IRDA_CONSTS_SVH
`define OVS_TICKS 5'h10
`define OVS_LAST 4'hf
`define OVS_MID 4'h7
`define IR_PULSE_TICKS 4'h3
`define IR_WIN_EARLY 5'h04
`define IR_WIN_LATE 5'h08
`define IR_CNT_MAX 5'h18
`define IR_CNT_OPEN 5'h0c
`define DATA_LAST 3'h7
`define BAUD_RESET 16'h0000
`define MP_OFF 2'h0
`define MP_MATCH_BIT 1
`endif

// [design/uart_irda_pkg.sv]
// types shared by the serial block, its assertions and its testbench
`default_nettype none
package uart_irda_pkg;
   typedef struct packed {
      logic rx_enable;
      logic tx_enable;
      logic parity_enable;
      logic parity_odd;
      logic two_stop;
      logic [1:0] multiproc_mode_select;
      logic multiproc_bit_tx;
      logic driver_enable_polarity;
      logic baud_readback_ctl;
      logic rx_data_irq_mask;
      logic infrared_codec_enable;
      logic [7:0] node_address;
      logic [15:0] baud_divider;
   } uart_cfg_t;
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } rx_word_t;
   typedef enum logic [2:0] {
      SER_IDLE = 3'h0,
      SER_START = 3'h1,
      SER_DATA = 3'h3,
      SER_NINTH = 3'h2,
      SER_STOP = 3'h6
   } ser_state_t;
   typedef enum logic {
      DEC_IDLE = 1'b0,
      DEC_TRACK = 1'b1
   } dec_state_t;
endpackage : uart_irda_pkg
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the serial block with infrared codec
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_irda_pkg::*;
   localparam int BIT = 32;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   uart_cfg_t cfg = '0;
   logic tx_write = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic rx_read = 1'b0;
   logic err_clear = 1'b0;
   logic tx_data_empty_q, tx_irq_q, rx_byte_available_q, rx_irq_q, parity_err_q;
   logic framing_err_q, overrun_err_q, uart_txd_q, uart_rxd, ir_txd_q, ir_rxd;
   logic line_driver_enable_q;
   logic [15:0] baud_read_q;
   rx_word_t rx_word_q;
   rx_word_t last;
   logic [10:0] v;
   logic ir_last = 1'b0;
   int mismatches = 0;
   int cmp_count = 0;
   int irqs = 0;
   int ir_rises = 0;
   int txd_low = 0;
   int base;
   uart_irda u_dut (.mclk, .reset_n, .cfg, .tx_write, .tx_byte, .tx_data_empty_q, .tx_irq_q,
      .rx_byte_available_q, .rx_word_q, .rx_read, .rx_irq_q, .parity_err_q, .framing_err_q,
      .overrun_err_q, .err_clear, .baud_read_q, .uart_txd_q, .uart_rxd, .ir_txd_q, .ir_rxd,
      .line_driver_enable_q);
   uart_peer #(.BIT(BIT)) u_peer (.mclk, .txd(uart_txd_q), .rxd(uart_rxd), .ir_rxd);
   always #2.5 mclk = ~mclk;
   always @(negedge mclk) begin
      if (rx_irq_q === 1'b1) irqs++;
      if (ir_txd_q === 1'b1 && ir_last !== 1'b1) ir_rises++;
      if (uart_txd_q !== 1'b1) txd_low++;
      ir_last <= ir_txd_q;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic print_verdict();
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   function automatic logic [10:0] frame(input logic [8:0] d, input logic nine);
      return {1'b1, nine ? d[8] : 1'b1, d[7:0], 1'b0};
   endfunction : frame
   task automatic put_tx(input logic [7:0] b);
      @(negedge mclk);
      for (int i = 0; i < 2000 && tx_data_empty_q !== 1'b1; i++) @(negedge mclk);
      tx_byte = b;
      tx_write = 1'b1;
      @(negedge mclk);
      tx_write = 1'b0;
      check("tx_empty", 16'h0000, {15'h0000, tx_data_empty_q});
   endtask : put_tx
   task automatic pulse_read();
      rx_read = 1'b1;
      @(negedge mclk);
      rx_read = 1'b0;
      @(negedge mclk);
   endtask : pulse_read
   task automatic pop_rx(input rx_word_t exp);
      for (int i = 0; i < 400 && rx_byte_available_q !== 1'b1; i++) @(negedge mclk);
      check("rx_word", {6'h00, 1'b1, exp}, {6'h00, rx_byte_available_q, rx_word_q});
      pulse_read();
   endtask : pop_rx
   initial begin
      cfg.baud_divider = 16'h0001;
      cfg.tx_enable = 1'b1;
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      check("tx_empty", 16'h0001, {15'h0000, tx_data_empty_q});
      check("tx_irq", 16'h0001, {15'h0000, tx_irq_q});
      // both address flag values, each with its own driver enable polarity
      for (int k = 0; k < 2; k++) begin
         cfg.multiproc_mode_select = 2'h1;
         cfg.multiproc_bit_tx = k[0];
         cfg.driver_enable_polarity = ~k[0];
         fork
            put_tx(8'ha5 ^ {8{k[0]}});
            u_peer.recv(11, v);
         join
         @(negedge mclk);
         check("tx_frame", {5'h00, frame({k[0], 8'ha5 ^ {8{k[0]}}}, 1'b1)}, {5'h00, v});
      end
      cfg.multiproc_mode_select = 2'h0;
      u_peer.send(frame(9'h05a, 1'b0), 10, 1'b0);
      repeat (4) @(negedge mclk);
      check("rx_off", 16'h0000, {15'h0000, rx_byte_available_q});
      cfg.rx_enable = 1'b1;
      for (int m = 0; m < 2; m++) begin
         cfg.rx_data_irq_mask = m[0];
         base = irqs;
         u_peer.send(frame(9'h0c3 + 9'(m), 1'b0), 10, 1'b0);
         pop_rx(9'h0c3 + 9'(m));
         check("rx_irq", 16'(1 - m), 16'(irqs - base));
      end
      // third byte with a full buffer and data requests masked
      base = irqs;
      for (int i = 0; i < 3; i++) u_peer.send(frame(9'h010 + 9'(i), 1'b0), 10, 1'b0);
      repeat (4) @(negedge mclk);
      check("overrun", 16'h0001, {15'h0000, overrun_err_q});
      check("err_irq", 16'h0001, 16'(irqs - base));
      pop_rx(9'h010);
      pop_rx(9'h011);
      cfg.rx_enable = 1'b0;
      err_clear = 1'b1;
      @(negedge mclk);
      err_clear = 1'b0;
      @(negedge mclk);
      check("err_clear", 16'h0000, {15'h0000, overrun_err_q});
      cfg.multiproc_mode_select = 2'h2;
      cfg.node_address = 8'h42;
      cfg.rx_data_irq_mask = 1'b0;
      cfg.rx_enable = 1'b1;
      u_peer.send(frame(9'h117, 1'b1), 11, 1'b0);
      u_peer.send(frame(9'h099, 1'b1), 11, 1'b0);
      u_peer.send(frame(9'h142, 1'b1), 11, 1'b0);
      u_peer.send(frame(9'h066, 1'b1), 11, 1'b0);
      repeat (4) @(negedge mclk);
      last = '0;
      for (int i = 0; i < 4 && rx_byte_available_q === 1'b1; i++) begin
         check("rx_skip", 16'h0001, {15'h0000, rx_word_q !== 9'h099});
         last = rx_word_q;
         pulse_read();
      end
      check("rx_match", 16'h0066, {7'h00, last});
      // even parity: a wrong parity bit keeps the byte; with parity off, a low stop bit drops it
      cfg.multiproc_mode_select = 2'h0;
      cfg.parity_enable = 1'b1;
      u_peer.send(frame(9'h103, 1'b1), 11, 1'b0);
      pop_rx(9'h103);
      check("parity_err", 16'h0001, {15'h0000, parity_err_q});
      cfg.parity_enable = 1'b0;
      u_peer.send(frame(9'h000, 1'b1), 11, 1'b0);
      repeat (4) @(negedge mclk);
      check("framing_err", 16'h0001, {14'h0000, rx_byte_available_q, framing_err_q});
      // codec enabled before traffic so no stray pulse leaves the block
      cfg.rx_enable = 1'b0;
      cfg.multiproc_mode_select = 2'h0;
      cfg.infrared_codec_enable = 1'b1;
      cfg.rx_enable = 1'b1;
      u_peer.send(frame(9'h0b2, 1'b0), 10, 1'b1);
      pop_rx(9'h0b2);
      base = ir_rises;
      txd_low = 0;
      put_tx(8'hb2);
      repeat (12 * BIT) @(negedge mclk);
      check("ir_pulses", 16'h0005, 16'(ir_rises - base));
      check("txd_idle", 16'h0000, 16'(txd_low));
      cfg.infrared_codec_enable = 1'b0;
      repeat (2) @(negedge mclk);
      check("baud_reload", 16'h0001, baud_read_q);
      cfg.baud_readback_ctl = 1'b1;
      base = irqs;
      repeat (20) @(negedge mclk);
      check("rx_on_irq", 16'h0000, 16'(irqs - base));
      cfg.rx_enable = 1'b0;
      repeat (4) @(negedge mclk);
      base = irqs;
      repeat (20) @(negedge mclk);
      check("timer_irq", 16'h000a, 16'(irqs - base));
      cfg.baud_readback_ctl = 1'b0;
      repeat (4) @(negedge mclk);
      base = irqs;
      repeat (20) @(negedge mclk);
      check("timer_off", 16'h0000, 16'(irqs - base));
      print_verdict();
   end
   // the sequence needs under 8000 cycles
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire

// [testbench/uart_irda_sva.sv]
// port assertions for the serial block
`default_nettype none
module uart_irda_sva (
   input wire logic mclk,
   input wire logic reset_n,
   input wire uart_irda_pkg::uart_cfg_t cfg,
   input wire logic tx_write,
   input wire logic tx_data_empty_q,
   input wire logic tx_irq_q,
   input wire logic rx_byte_available_q,
   input wire logic rx_read,
   input wire logic rx_irq_q,
   input wire logic parity_err_q,
   input wire logic framing_err_q,
   input wire logic overrun_err_q,
   input wire logic err_clear,
   input wire logic [15:0] baud_read_q,
   input wire logic uart_txd_q,
   input wire logic line_driver_enable_q
);
   import uart_irda_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   tx_irq_a: assert property (cfg.tx_enable && tx_data_empty_q |=> tx_irq_q)
      else $error("transmit request missing with empty holding register");
   tx_take_a: assert property (tx_write && tx_data_empty_q |=> !tx_data_empty_q)
      else $error("holding register not full after write");
   tx_load_a: assert property (!tx_data_empty_q && cfg.tx_enable |-> ##[1:1000] tx_data_empty_q)
      else $error("written byte never moved to shifter");
   de_pol_a: assert property (!uart_txd_q && $past(!uart_txd_q) |->
      line_driver_enable_q == !cfg.driver_enable_polarity)
      else $error("driver enable wrong level while sending");
   rx_pop_a: assert property (rx_read && rx_byte_available_q |=> !rx_byte_available_q)
      else $error("byte available did not drop after read");
   baud_reload_a: assert property (!cfg.baud_readback_ctl |=> baud_read_q == $past(cfg.baud_divider))
      else $error("baud read not the reload value");
   baud_live_a: assert property ((cfg.baud_readback_ctl && cfg.baud_divider != 16'h0000) [*2]
      |=> baud_read_q != $past(baud_read_q))
      else $error("baud read not the live count");
   timer_irq_a: assert property ((!cfg.rx_enable && cfg.baud_readback_ctl
      && cfg.baud_divider == 16'h0001) [*4] |-> ##[0:2] rx_irq_q)
      else $error("timer request missing at baud count zero");
   err_only_a: assert property (cfg.rx_enable && cfg.rx_data_irq_mask && rx_irq_q
      |-> ##[0:1] (parity_err_q || framing_err_q || overrun_err_q))
      else $error("masked receive request without error");
   err_clear_a: assert property (err_clear && !cfg.rx_enable
      |=> !(parity_err_q || framing_err_q || overrun_err_q))
      else $error("error flags not cleared");
endmodule : uart_irda_sva
bind uart_irda uart_irda_sva u_sva (.mclk, .reset_n, .cfg, .tx_write, .tx_data_empty_q,
   .tx_irq_q, .rx_byte_available_q, .rx_read, .rx_irq_q, .parity_err_q, .framing_err_q,
   .overrun_err_q, .err_clear, .baud_read_q, .uart_txd_q, .line_driver_enable_q);
`default_nettype wire

// [testbench/uart_peer.sv]
// remote serial node: drives plain or infrared frames and captures sent ones
`default_nettype none
module uart_peer #(
   parameter int BIT = 32
) (
   input wire logic mclk,
   input wire logic txd,
   output logic rxd,
   output logic ir_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   // both lines rest at the mark level between frames, as a real node leaves them
   initial begin
      rxd = 1'b1;
      ir_rxd = 1'b1;
   end
   // f is lsb first with start and stop; infrared gives a 3/16 bit low pulse per 0 bit
   task automatic send(input logic [10:0] f, input int n, input logic ir);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         if (ir) begin
            ir_rxd = f[i];
            repeat (BIT * 3 / 16) @(negedge mclk);
            ir_rxd = 1'b1;
            repeat (BIT - BIT * 3 / 16 - 1) @(negedge mclk);
         end else begin
            rxd = f[i];
            repeat (BIT - 1) @(negedge mclk);
         end
      end
   endtask : send
   // samples in mid bit, start bit first
   task automatic recv(input int n, output logic [10:0] v);
      v = '0;
      @(negedge txd);
      repeat (BIT / 2) @(negedge mclk);
      for (int i = 0; i < n; i++) begin
         v[i] = txd;
         repeat (BIT) @(negedge mclk);
      end
   endtask : recv
endmodule : uart_peer
`default_nettype wire
